// file: hdl/vta_defs.svh
`ifndef VTA_DEFS_SVH
`define VTA_DEFS_SVH

// byte addresses of the register window
`define VTA_OFF_WORD0        16'h0400
`define VTA_OFF_UNTAG        16'h0404
`define VTA_OFF_FWD          16'h0408
`define VTA_OFF_INDEX        16'h040c
`define VTA_OFF_CTRL         16'h040e

// first entry word field positions
`define VTA_W0_VALID_BIT     31
`define VTA_W0_FO_BIT        27
`define VTA_W0_PRIO_HI       26
`define VTA_W0_PRIO_LO       24
`define VTA_W0_MSTP_HI       14
`define VTA_W0_MSTP_LO       12
`define VTA_W0_FID_HI        6
`define VTA_W0_FID_LO        0

// port masks in second and third entry words
`define VTA_MASK_HI          5
`define VTA_MASK_LO          0

// index and control field positions
`define VTA_INDEX_HI         11
`define VTA_INDEX_LO         0
`define VTA_CTRL_START_BIT   7
`define VTA_CTRL_ACT_HI      1
`define VTA_CTRL_ACT_LO      0

// reset values
`define VTA_RST_INDEX        12'h000
`define VTA_RST_ACTION       2'h0
`define VTA_RST_START        1'b0
`define VTA_RST_CLR_CNT      12'h000

// clear sweep ends on the last table address
`define VTA_CLR_LAST         12'hfff

`endif

// file: hdl/vta_pkg.sv
package vta_pkg;

  // action codes of the access control byte
  typedef enum logic [1:0] {
    VTA_ACT_NOP   = 2'b00,
    VTA_ACT_WRITE = 2'b01,
    VTA_ACT_READ  = 2'b10,
    VTA_ACT_CLEAR = 2'b11
  } vta_action_t;

  // access sequencer states
  typedef enum logic [1:0] {
    VTA_ST_IDLE    = 2'b00,
    VTA_ST_RD_WAIT = 2'b01,
    VTA_ST_CLEAR   = 2'b10
  } vta_state_t;

  // one stored table entry, reserved bits not kept
  typedef struct packed {
    logic       valid;
    logic       use_entry_port_map;
    logic [2:0] priority_lvl;
    logic [2:0] mstp_index;
    logic [6:0] filter_group_id;
    logic [5:0] untag_mask;
    logic [5:0] forward_mask;
  } vta_entry_t;

endpackage : vta_pkg

// file: hdl/vta_table.sv
`timescale 1ns/1ps

// vlan entry storage, one write port and two synchronous read ports
module vta_table #(
  parameter int AW = 12
) (
  input wire logic core_clk,
  vta_tbl_if.mem   tbl
);

  // no reset on the array: contents stand until written or cleared
  vta_pkg::vta_entry_t mem [0:(1<<AW)-1];

  // software port, read returns the old word on a same-cycle write
  always_ff @(posedge core_clk) begin
    if (tbl.sw_we) begin
      mem[tbl.sw_addr] <= tbl.sw_wdata;
    end
    tbl.sw_rdata <= mem[tbl.sw_addr];
  end

  // lookup port for the forwarding path
  always_ff @(posedge core_clk) begin
    tbl.lk_rdata <= mem[tbl.lk_addr];
  end

endmodule : vta_table

// file: hdl/vta_tbl_if.sv
`timescale 1ns/1ps

// carries the software and lookup ports of the table memory
interface vta_tbl_if #(
  parameter int AW = 12
);
  logic [AW-1:0]          sw_addr;   // software access address
  logic                   sw_we;     // software write strobe
  vta_pkg::vta_entry_t    sw_wdata;  // software write data
  vta_pkg::vta_entry_t    sw_rdata;  // software read data, one cycle late
  logic [AW-1:0]          lk_addr;   // forwarding lookup address
  vta_pkg::vta_entry_t    lk_rdata;  // forwarding lookup data, one cycle late

  modport ctrl (
    output sw_addr,
    output sw_we,
    output sw_wdata,
    output lk_addr,
    input  sw_rdata,
    input  lk_rdata
  );

  modport mem (
    input  sw_addr,
    input  sw_we,
    input  sw_wdata,
    input  lk_addr,
    output sw_rdata,
    output lk_rdata
  );
endinterface : vta_tbl_if

// file: hdl/vta_top.sv
`timescale 1ns/1ps
`include "vta_defs.svh"

// Contract
// RULE_01: valid bit 31 gates entry use
// RULE_02: option set forwards to entry mask
// RULE_03: option clear uses other port map
// RULE_04: word0 bits 26:24 hold priority
// RULE_05: word0 bits 14:12 hold spanning-tree index
// RULE_06: word0 bits 6:0 hold filter id
// RULE_07: word1 bits 5:0 untag per port
// RULE_08: word2 bits 5:0 forward mask
// RULE_09: index bits 11:0 select entry
// RULE_10: start bit self-clears when action done
// RULE_11: action codes nop write read clear-all
// RULE_12: read loads data, write stores data
// RULE_13: reserved bits read zero, ignore writes
module vta_top #(
  parameter int AW = 12
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [11:0] lookup_vid,
  input  wire logic [5:0]  other_port_map,
  output logic             lookup_hit,
  output logic      [5:0]  egress_map,
  output logic      [5:0]  untag_map,
  output logic      [2:0]  lookup_priority,
  output logic      [2:0]  lookup_mstp_index,
  output logic      [6:0]  lookup_filter_group_id
);

  vta_pkg::vta_entry_t entry;        // the three entry-data registers
  logic [11:0]         index;        // entry selector
  logic                start;        // start / busy flag
  logic [1:0]          action;       // selected action code
  vta_pkg::vta_state_t state;        // sequencer state
  vta_pkg::vta_state_t next_state;   // sequencer next state
  logic [11:0]         clr_cnt;      // clear sweep address
  logic                done;         // action finishes this cycle
  logic                sw_open;      // software may write registers
  logic [5:0]          other_d;      // other map aligned to table data

  vta_tbl_if #(.AW(AW)) tbl ();

  vta_table #(.AW(AW)) u_table (
    .core_clk (core_clk),
    .tbl      (tbl)
  );

  // pack an entry into the first word, reserved bits zero
  function automatic logic [31:0] word0_of(input vta_pkg::vta_entry_t e);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`VTA_W0_VALID_BIT] = e.valid;                                    // RULE_01
    w[`VTA_W0_FO_BIT] = e.use_entry_port_map;                          // RULE_02
    w[`VTA_W0_PRIO_HI:`VTA_W0_PRIO_LO] = e.priority_lvl;               // RULE_04
    w[`VTA_W0_MSTP_HI:`VTA_W0_MSTP_LO] = e.mstp_index;                 // RULE_05
    w[`VTA_W0_FID_HI:`VTA_W0_FID_LO] = e.filter_group_id;              // RULE_06
    return w;
  endfunction : word0_of

  // widen a port mask into a word, upper bits zero
  function automatic logic [31:0] mask_word(input logic [5:0] m);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`VTA_MASK_HI:`VTA_MASK_LO] = m;                                  // RULE_13
    return w;
  endfunction : mask_word

  // byte of a word at a lane, lane 0 is the most significant byte
  function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] lane);
    logic [7:0] b;
    b = w[8*(3-lane) +: 8];
    return b;
  endfunction : get_byte

  // replace one byte of a word, same lane order
  function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] lane,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = w;
    r[8*(3-lane) +: 8] = d;
    return r;
  endfunction : put_byte

  // word images of the readable registers
  logic [31:0] w0_img;
  logic [31:0] w1_img;
  logic [31:0] w2_img;
  logic [31:0] w0_new;
  logic [31:0] w1_new;
  logic [31:0] w2_new;
  logic [1:0]  lane;

  assign w0_img = word0_of(entry);
  assign w1_img = mask_word(entry.untag_mask);                         // RULE_07
  assign w2_img = mask_word(entry.forward_mask);                       // RULE_08
  assign lane   = reg_addr[1:0];
  assign w0_new = put_byte(w0_img, lane, reg_wdata);
  assign w1_new = put_byte(w1_img, lane, reg_wdata);
  assign w2_new = put_byte(w2_img, lane, reg_wdata);

  // registers are locked while an action runs, so results cannot be torn
  assign sw_open = reg_wr && !start && (state == vta_pkg::VTA_ST_IDLE);

  // entry-data registers: software bytes, or table data after a read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      entry <= '0;
    end else if (state == vta_pkg::VTA_ST_RD_WAIT) begin
      entry <= tbl.sw_rdata;                                           // RULE_12
    end else if (sw_open && reg_addr[15:2] == `VTA_OFF_WORD0 >> 2) begin
      // unpacking the new word drops reserved bits
      entry.valid              <= w0_new[`VTA_W0_VALID_BIT];           // RULE_01
      entry.use_entry_port_map <= w0_new[`VTA_W0_FO_BIT];              // RULE_02
      entry.priority_lvl       <= w0_new[`VTA_W0_PRIO_HI:`VTA_W0_PRIO_LO]; // RULE_04
      entry.mstp_index         <= w0_new[`VTA_W0_MSTP_HI:`VTA_W0_MSTP_LO]; // RULE_05
      entry.filter_group_id    <= w0_new[`VTA_W0_FID_HI:`VTA_W0_FID_LO];   // RULE_06
    end else if (sw_open && reg_addr[15:2] == `VTA_OFF_UNTAG >> 2) begin
      entry.untag_mask <= w1_new[`VTA_MASK_HI:`VTA_MASK_LO];           // RULE_07
    end else if (sw_open && reg_addr[15:2] == `VTA_OFF_FWD >> 2) begin
      entry.forward_mask <= w2_new[`VTA_MASK_HI:`VTA_MASK_LO];         // RULE_08
    end
  end

  // index register, high byte at the lower address
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      index <= `VTA_RST_INDEX;
    end else if (sw_open && reg_addr == `VTA_OFF_INDEX) begin
      index[11:8] <= reg_wdata[3:0];                                   // RULE_13
    end else if (sw_open && reg_addr == `VTA_OFF_INDEX + 16'h0001) begin
      index[7:0] <= reg_wdata;                                         // RULE_09
    end
  end

  // control byte: software sets start, the sequencer clears it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      start  <= `VTA_RST_START;
      action <= `VTA_RST_ACTION;
    end else if (done) begin
      start <= 1'b0;                                                   // RULE_10
    end else if (sw_open && reg_addr == `VTA_OFF_CTRL) begin
      start  <= reg_wdata[`VTA_CTRL_START_BIT];                        // RULE_10
      action <= reg_wdata[`VTA_CTRL_ACT_HI:`VTA_CTRL_ACT_LO];          // RULE_11
    end
  end

  // sequencer decisions and table port drive
  always_comb begin
    next_state   = state;
    done         = 1'b0;
    tbl.sw_we    = 1'b0;
    tbl.sw_addr  = index[AW-1:0];                                      // RULE_09
    tbl.sw_wdata = entry;
    case (state)
      vta_pkg::VTA_ST_IDLE: begin
        if (start) begin
          case (vta_pkg::vta_action_t'(action))                        // RULE_11
            vta_pkg::VTA_ACT_NOP: begin
              done = 1'b1;
            end
            vta_pkg::VTA_ACT_WRITE: begin
              tbl.sw_we = 1'b1;                                        // RULE_12
              done      = 1'b1;
            end
            vta_pkg::VTA_ACT_READ: begin
              next_state = vta_pkg::VTA_ST_RD_WAIT;                    // RULE_12
            end
            default: begin
              next_state = vta_pkg::VTA_ST_CLEAR;
            end
          endcase
        end
      end
      vta_pkg::VTA_ST_RD_WAIT: begin
        // table data is captured into entry on this edge
        done       = 1'b1;
        next_state = vta_pkg::VTA_ST_IDLE;
      end
      vta_pkg::VTA_ST_CLEAR: begin
        // one entry zeroed per cycle, whole table in 4096 cycles
        tbl.sw_we    = 1'b1;                                           // RULE_11
        tbl.sw_addr  = clr_cnt[AW-1:0];
        tbl.sw_wdata = '0;
        if (clr_cnt == `VTA_CLR_LAST) begin
          done       = 1'b1;
          next_state = vta_pkg::VTA_ST_IDLE;
        end
      end
      default: begin
        next_state = vta_pkg::VTA_ST_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= vta_pkg::VTA_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // clear sweep counter, held at zero outside a sweep
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clr_cnt <= `VTA_RST_CLR_CNT;
    end else if (state == vta_pkg::VTA_ST_CLEAR) begin
      clr_cnt <= clr_cnt + 12'h001;
    end else begin
      clr_cnt <= `VTA_RST_CLR_CNT;
    end
  end

  // register read port, one cycle latency, unmapped reads zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr[15:2] == `VTA_OFF_WORD0 >> 2) begin
        reg_rdata <= get_byte(w0_img, lane);                           // RULE_13
      end else if (reg_addr[15:2] == `VTA_OFF_UNTAG >> 2) begin
        reg_rdata <= get_byte(w1_img, lane);
      end else if (reg_addr[15:2] == `VTA_OFF_FWD >> 2) begin
        reg_rdata <= get_byte(w2_img, lane);
      end else if (reg_addr == `VTA_OFF_INDEX) begin
        reg_rdata <= {4'h0, index[11:8]};                              // RULE_13
      end else if (reg_addr == `VTA_OFF_INDEX + 16'h0001) begin
        reg_rdata <= index[7:0];
      end else if (reg_addr == `VTA_OFF_CTRL) begin
        reg_rdata <= {start, 5'h00, action};                           // RULE_10
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // lookup address goes straight to the memory's second port
  assign tbl.lk_addr = lookup_vid[AW-1:0];

  // other map delayed to meet the table data one cycle later
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      other_d <= 6'h00;
    end else begin
      other_d <= other_port_map;
    end
  end

  // forwarding result, an invalid entry falls back to the other map
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lookup_hit             <= 1'b0;
      egress_map             <= 6'h00;
      untag_map              <= 6'h00;
      lookup_priority        <= 3'h0;
      lookup_mstp_index      <= 3'h0;
      lookup_filter_group_id <= 7'h00;
    end else if (tbl.lk_rdata.valid) begin                             // RULE_01
      lookup_hit             <= 1'b1;
      if (tbl.lk_rdata.use_entry_port_map) begin
        egress_map <= tbl.lk_rdata.forward_mask;                       // RULE_02
      end else begin
        egress_map <= other_d;                                         // RULE_03
      end
      untag_map              <= tbl.lk_rdata.untag_mask;               // RULE_07
      lookup_priority        <= tbl.lk_rdata.priority_lvl;             // RULE_04
      lookup_mstp_index      <= tbl.lk_rdata.mstp_index;               // RULE_05
      lookup_filter_group_id <= tbl.lk_rdata.filter_group_id;          // RULE_06
    end else begin
      lookup_hit             <= 1'b0;
      egress_map             <= other_d;                               // RULE_01
      untag_map              <= 6'h00;
      lookup_priority        <= 3'h0;
      lookup_mstp_index      <= 3'h0;
      lookup_filter_group_id <= 7'h00;
    end
  end

endmodule : vta_top

// file: verif/vlan_table_access_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module vlan_table_access_bench;
  // one row: entry written, lookup stimulus, expected results
  typedef struct {
    logic [11:0] vid;
    logic [31:0] w0, um, fm;
    logic [5:0]  other;
    logic [31:0] exp_w0;
    logic        exp_hit;
    logic [5:0]  exp_egr;
  } vta_row_t;

  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata, d;
  logic [11:0] lookup_vid = 12'h000;
  logic [5:0]  other_port_map = 6'h00;
  logic        lookup_hit;
  logic [5:0]  egress_map, untag_map;
  logic [2:0]  lookup_priority, lookup_mstp_index;
  logic [6:0]  lookup_filter_group_id;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  vta_row_t    rows [4] = '{
    '{12'h001, 32'hffffffff, 32'hffffffff, 32'hffffffea, 6'h15, 32'h8f00707f, 1'b1, 6'h2a},
    '{12'hfff, 32'h80002055, 32'h00000001, 32'h0000003f, 6'h15, 32'h80002055, 1'b1, 6'h15},
    '{12'h800, 32'h7d00107f, 32'h0000002a, 32'h00000011, 6'h2c, 32'h0d00107f, 1'b0, 6'h2c},
    '{12'h000, 32'h8a003001, 32'h00000000, 32'h00000000, 6'h3f, 32'h8a003001, 1'b1, 6'h00}};

  vta_top #(.AW(12)) dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lookup_vid(lookup_vid), .other_port_map(other_port_map), .lookup_hit(lookup_hit),
    .egress_map(egress_map), .untag_map(untag_map), .lookup_priority(lookup_priority),
    .lookup_mstp_index(lookup_mstp_index), .lookup_filter_group_id(lookup_filter_group_id));

  // 50 ns period
  always #25 core_clk = ~core_clk;

  // one-cycle write strobe, launched on the falling edge
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  // read strobe; data sampled a cycle late since it holds anyway
  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e, input string nm);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
    if (nm != "") `CHK(nm, e, d)
  endtask : chk_rd

  // big-endian word over four byte lanes
  task automatic wr32(input logic [15:0] b, input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(b + 16'(i), v[31-8*i -: 8]);
  endtask : wr32

  task automatic chk32(input logic [15:0] b, input logic [31:0] e, input string nm);
    for (int i = 0; i < 4; i++) chk_rd(b + 16'(i), e[31-8*i -: 8], nm);
  endtask : chk32

  // poll until start drops; each poll is three cycles, so 1500 polls outlast the clear sweep
  task automatic wait_done();
    d = 8'h80;
    for (int n = 0; n < 1500 && d[7]; n++) chk_rd(16'h040e, 8'h00, "");
    if (d[7]) `CHK("done", 1'b0, d[7])
  endtask : wait_done

  task automatic act(input logic [1:0] code);
    wr(16'h040e, {6'h20, code});
    wait_done();
  endtask : act

  task automatic set_index(input logic [11:0] v);
    wr(16'h040c, {4'h0, v[11:8]});
    wr(16'h040d, v[7:0]);
  endtask : set_index

  // vid and other map presented together, outputs two edges later
  task automatic look(input logic [11:0] v, input logic [5:0] o);
    @(negedge core_clk);
    lookup_vid = v;
    other_port_map = o;
    repeat (3) @(negedge core_clk);
  endtask : look

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // hang guard: two clears plus traffic fit well inside
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    for (int a = 16'h0400; a < 16'h0410; a++) chk_rd(16'(a), 8'h00, "reset");
    act(2'b11);
    chk_rd(16'h040e, 8'h03, "ctrl");
    // table rows: store all, then read all back to catch aliasing
    foreach (rows[i]) begin
      wr32(16'h0400, rows[i].w0);
      wr32(16'h0404, rows[i].um);
      wr32(16'h0408, rows[i].fm);
      set_index(rows[i].vid);
      act(2'b01);
    end
    foreach (rows[i]) begin
      wr32(16'h0400, 32'hffffffff);
      wr32(16'h0404, 32'hffffffff);
      wr32(16'h0408, 32'hffffffff);
      set_index(rows[i].vid);
      act(2'b10);
      chk32(16'h0400, rows[i].exp_w0, "word0");
      chk32(16'h0404, rows[i].um & 32'h3f, "untag");
      chk32(16'h0408, rows[i].fm & 32'h3f, "fwd");
      look(rows[i].vid, rows[i].other);
      `CHK("hit", rows[i].exp_hit, lookup_hit)
      `CHK("egress", rows[i].exp_egr, egress_map)
      `CHK("untagmap", rows[i].exp_hit ? rows[i].um[5:0] : 6'h00, untag_map)
      `CHK("prio", rows[i].exp_hit ? rows[i].exp_w0[26:24] : 3'h0, lookup_priority)
      `CHK("mstp", rows[i].exp_hit ? rows[i].exp_w0[14:12] : 3'h0, lookup_mstp_index)
      `CHK("fid", rows[i].exp_hit ? rows[i].exp_w0[6:0] : 7'h00, lookup_filter_group_id)
    end
    // reserved and unmapped places
    wr(16'h040c, 8'hff);
    chk_rd(16'h040c, 8'h0f, "idxhi");
    wr(16'h040f, 8'hff);
    chk_rd(16'h040f, 8'h00, "unmapped");
    wr(16'h040e, 8'h7e);
    chk_rd(16'h040e, 8'h02, "ctrlrsvd");
    act(2'b00);
    chk_rd(16'h040e, 8'h00, "nop");
    // writes during a running clear are dropped
    wr(16'h040e, 8'h83);
    wr(16'h040d, 8'h55);
    chk_rd(16'h040e, 8'h83, "busy");
    wait_done();
    chk_rd(16'h040d, 8'h00, "locked");
    set_index(12'h001);
    act(2'b10);
    chk32(16'h0400, 32'h00000000, "cleared");
    look(12'h001, 6'h09);
    `CHK("clrhit", 1'b0, lookup_hit)
    `CHK("clregr", 6'h09, egress_map)
    conclude();
  end
endmodule : vlan_table_access_bench

// file: verif/vta_asserts.sv
`timescale 1ns/1ps

// port-level checker for the vlan table front end
module vta_asserts #(
  parameter int AW = 12
) (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [11:0] lookup_vid,
  input wire logic [5:0]  other_port_map,
  input wire logic        lookup_hit,
  input wire logic [5:0]  egress_map,
  input wire logic [5:0]  untag_map,
  input wire logic [2:0]  lookup_priority,
  input wire logic [2:0]  lookup_mstp_index,
  input wire logic [6:0]  lookup_filter_group_id
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // read strobe on a given byte address
  sequence rd_at(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence

  a_unmapped_zero: assert property (rd_at(16'h040f) |=> reg_rdata == 8'h00)
    else $error("unmapped byte did not read zero");
  a_ctrl_rsvd: assert property (rd_at(16'h040e) |=> reg_rdata[6:2] == 5'h00)
    else $error("control reserved bits not zero");
  a_index_rsvd: assert property (rd_at(16'h040c) |=> reg_rdata[7:4] == 4'h0)
    else $error("index upper nibble not zero");
  a_word0_mid: assert property (rd_at(16'h0401) |=> reg_rdata == 8'h00)
    else $error("entry word bits 23:16 not zero");
  a_word0_gap: assert property (rd_at(16'h0402) |=> (reg_rdata & 8'h8f) == 8'h00)
    else $error("entry word gap bits not zero");
  a_mask_upper: assert property (reg_rd && reg_addr inside {[16'h0404:16'h0406],
      [16'h0408:16'h040a]} |=> reg_rdata == 8'h00)
    else $error("port mask upper bytes not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_invalid_zero: assert property (!lookup_hit |-> {untag_map, lookup_priority,
      lookup_mstp_index, lookup_filter_group_id} == 16'h0000)
    else $error("invalid entry leaked fields");
  a_other_map: assert property (!lookup_hit |-> egress_map == $past(other_port_map, 2))
    else $error("miss did not pass other map");

  // main scenarios reached
  c_start: cover property (reg_wr && reg_addr == 16'h040e && reg_wdata[7]);
  c_hit: cover property (lookup_hit);
  c_done: cover property (rd_at(16'h040e) ##1 !reg_rdata[7]);
endmodule : vta_asserts

bind vta_top vta_asserts #(.AW(AW)) u_asserts (
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .lookup_vid(lookup_vid), .other_port_map(other_port_map), .lookup_hit(lookup_hit),
  .egress_map(egress_map), .untag_map(untag_map), .lookup_priority(lookup_priority),
  .lookup_mstp_index(lookup_mstp_index), .lookup_filter_group_id(lookup_filter_group_id));
